//--- hdl/vsp_ctrl.sv
// host-side controller: feeds a video core's stream input and drains its stream output
`timescale 1ns/10ps
// Contract
// - integrator drives both sides' clock enables from one shared signal
// - one-sided toggled clock enable needs a stream fifo between the sides
// - byte keep and strobe unused; driven all ones where a block needs them
// - ready is the only backward signal and carries no other information
// - beat moves when ready, valid, clock enable and reset released all high
// - after valid rises, data and markers hold until ready is sampled high
// - ready may come before, with or after valid, never combinational from it
// - a slave able to accept pre-asserts ready, or registers it next cycle
// - missing ready means constant one; valid-only sources need an elastic fifo
// - frame start marker high on exactly one beat, the frame's first pixel
// - frame start belongs to the whole beat, tied to its lowest byte
// - frame start may rise early only while valid stays low
// - line end marker high on exactly one beat, each line's last pixel
// - inputs sampled on rising edge, outputs change only after that edge
module vsp_ctrl
    import vsp_pkg::*;
#(
    parameter int DW = 24,
    parameter int UW = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic dev_rst_n,
    output logic dev_clk_en,
    output logic [DW-1:0] m_tdata,
    output logic m_tvalid,
    input wire logic m_tready,
    output logic [UW-1:0] m_tuser,
    output logic m_tlast,
    output logic [DW/8-1:0] m_tkeep,
    output logic [DW/8-1:0] m_tstrb,
    input wire logic [DW-1:0] s_tdata,
    input wire logic s_tvalid,
    output logic s_tready,
    input wire logic [UW-1:0] s_tuser,
    input wire logic s_tlast
);
    typedef struct packed {
        logic [VSP_CTRL_W-1:0] ctrl;
        logic [15:0] width;
        logic [15:0] height;
        logic [15:0] wlat;
        logic [15:0] hlat;
        logic [15:0] x;
        logic [15:0] y;
        vsp_src_e state;
        logic m_valid;
        logic [DW-1:0] m_data;
        logic m_sof;
        logic m_eol;
        logic [DW/8-1:0] keep;
        logic s_ready;
        logic [15:0] tx_frames;
        logic [15:0] rx_frames;
        logic [15:0] rx_lines;
        logic [DW-1:0] rx_last;
        logic rx_sof_seen;
        logic ack;
        logic [31:0] dat;
        logic ce;
        logic dev_rst_n;
    } vsp_state_s;

    vsp_state_s q_reg;
    vsp_state_s q_next;
    logic tx_take;
    logic rx_take;
    logic tx_last_x;
    logic tx_last_y;
    logic wb_req;

    function automatic logic [15:0] vsp_merge16(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [1:0] sel);
        vsp_merge16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // handshake conditions see only registered outputs and same-clock inputs
    assign tx_take = q_reg.m_valid & m_tready & q_reg.ce & q_reg.dev_rst_n;
    assign rx_take = q_reg.s_ready & s_tvalid & q_reg.ce & q_reg.dev_rst_n;
    assign tx_last_x = (q_reg.x == 16'(q_reg.wlat - 16'h0001));
    assign tx_last_y = (q_reg.y == 16'(q_reg.hlat - 16'h0001));
    assign wb_req = wb_cyc_i & wb_stb_i;

    always_comb begin
        logic start;
        logic [15:0] nx;
        start = 1'b0;
        nx = 16'h0000;
        q_next = q_reg;
        // ack one cycle after the request; write lands at the edge the master sees ack
        q_next.ack = wb_req & ~q_reg.ack;
        q_next.dat = 32'h00000000;
        if (wb_req && !q_reg.ack && !wb_we_i) begin
            case (wb_adr_i)
                VSP_CTRL_OFS: q_next.dat = {28'h0000000, q_reg.ctrl};
                VSP_FRAME_OFS: q_next.dat = {q_reg.height, q_reg.width};
                VSP_COUNT_OFS: q_next.dat = {q_reg.rx_frames, q_reg.tx_frames};
                VSP_RXDATA_OFS: q_next.dat = {{(32-DW){1'b0}}, q_reg.rx_last};
                VSP_STATUS_OFS: q_next.dat = {30'h0, q_reg.rx_sof_seen,
                                              q_reg.state == VSP_SRC_SEND};
                VSP_LINES_OFS: q_next.dat = {16'h0000, q_reg.rx_lines};
                default: q_next.dat = 32'h00000000;
            endcase
        end
        if (wb_req && q_reg.ack && wb_we_i) begin
            case (wb_adr_i)
                VSP_CTRL_OFS: begin
                    if (wb_sel_i[0]) begin
                        q_next.ctrl = wb_dat_i[VSP_CTRL_W-1:0];
                    end
                end
                VSP_FRAME_OFS: begin
                    q_next.width = vsp_merge16(q_reg.width,
                        wb_dat_i[VSP_FRAME_WIDTH_LSB+:VSP_DIM_W], wb_sel_i[1:0]);
                    q_next.height = vsp_merge16(q_reg.height,
                        wb_dat_i[VSP_FRAME_HEIGHT_LSB+:VSP_DIM_W], wb_sel_i[3:2]);
                end
                default: begin
                end
            endcase
        end
        // one shared enable drives the device and gates this end's own transfers
        q_next.ce = q_reg.ctrl[VSP_CTRL_CLK_EN];
        q_next.dev_rst_n = ~q_reg.ctrl[VSP_CTRL_DEV_RST];
        // ready follows software only, so it is pre-asserted and never tracks valid
        q_next.s_ready = q_reg.ctrl[VSP_CTRL_SINK_EN];
        q_next.keep = {(DW/8){1'b1}};

        case (q_reg.state)
            VSP_SRC_IDLE: begin
                start = 1'b1;
            end
            VSP_SRC_SEND: begin
                if (tx_take) begin
                    if (tx_last_x && tx_last_y) begin
                        q_next.tx_frames = 16'(q_reg.tx_frames + 16'h0001);
                        q_next.state = VSP_SRC_IDLE;
                        q_next.m_valid = 1'b0;
                        q_next.m_sof = 1'b0;
                        q_next.m_eol = 1'b0;
                        start = 1'b1;
                    end else begin
                        nx = tx_last_x ? 16'h0000 : 16'(q_reg.x + 16'h0001);
                        q_next.x = nx;
                        q_next.y = tx_last_x ? 16'(q_reg.y + 16'h0001) : q_reg.y;
                        q_next.m_sof = 1'b0;
                        q_next.m_eol = (nx == 16'(q_reg.wlat - 16'h0001));
                        q_next.m_data = q_reg.m_data + {{(DW-1){1'b0}}, 1'b1};
                    end
                end
            end
            default: begin
                q_next.state = VSP_SRC_IDLE;
            end
        endcase
        // frame size is latched per frame so a rewrite never tears a running frame
        if (start && q_reg.ctrl[VSP_CTRL_SRC_EN] && q_reg.width != 16'h0000 &&
            q_reg.height != 16'h0000 && q_reg.dev_rst_n && q_reg.ce) begin
            // no frame starts while the shared enable is low, so nothing moves while gated
            q_next.state = VSP_SRC_SEND;
            q_next.wlat = q_reg.width;
            q_next.hlat = q_reg.height;
            q_next.x = 16'h0000;
            q_next.y = 16'h0000;
            q_next.m_valid = 1'b1;
            // marker rises with valid on the first pixel, carried by the whole beat
            q_next.m_sof = 1'b1;
            q_next.m_eol = (q_reg.width == 16'h0001);
            q_next.m_data = {DW{1'b0}};
        end
        // a device in reset has lost the frame, so the pending beat is abandoned
        if (!q_reg.dev_rst_n) begin
            q_next.state = VSP_SRC_IDLE;
            q_next.m_valid = 1'b0;
            q_next.m_sof = 1'b0;
            q_next.m_eol = 1'b0;
        end

        if (rx_take) begin
            q_next.rx_last = s_tdata;
            // higher user bits carry nothing and are ignored
            if (s_tuser[0]) begin
                q_next.rx_frames = 16'(q_reg.rx_frames + 16'h0001);
                q_next.rx_sof_seen = 1'b1;
            end
            if (s_tlast) begin
                q_next.rx_lines = 16'(q_reg.rx_lines + 16'h0001);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_reg <= '0;
            q_reg.ctrl <= VSP_CTRL_RST;
            q_reg.ce <= VSP_CTRL_RST[VSP_CTRL_CLK_EN];
            q_reg.width <= VSP_WIDTH_RST;
            q_reg.height <= VSP_HEIGHT_RST;
            q_reg.tx_frames <= VSP_COUNT_RST;
            q_reg.rx_frames <= VSP_COUNT_RST;
            q_reg.rx_lines <= VSP_COUNT_RST;
            q_reg.state <= VSP_SRC_IDLE;
            q_reg.keep <= {(DW/8){1'b1}};
        end else begin
            q_reg <= q_next;
        end
    end

    assign wb_dat_o = q_reg.dat;
    assign wb_ack_o = q_reg.ack;
    assign dev_rst_n = q_reg.dev_rst_n;
    assign dev_clk_en = q_reg.ce;
    assign m_tdata = q_reg.m_data;
    assign m_tvalid = q_reg.m_valid;
    assign m_tuser = UW'(q_reg.m_sof);
    assign m_tlast = q_reg.m_eol;
    assign m_tkeep = q_reg.keep;
    assign m_tstrb = q_reg.keep;
    assign s_tready = q_reg.s_ready;

    default clocking vsp_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_hold_beat;
        m_tvalid && !tx_take && dev_rst_n |=> m_tvalid && $stable(m_tdata) &&
            $stable(m_tlast) && $stable(m_tuser);
    endproperty
    a_hold_beat: assert property (p_hold_beat) else $error("beat changed before taken");

    property p_keep_ones;
        m_tkeep == {(DW/8){1'b1}} && m_tstrb == {(DW/8){1'b1}};
    endproperty
    a_keep_ones: assert property (p_keep_ones) else $error("keep or strobe not all ones");

    property p_sof_first;
        m_tvalid && m_tuser[0] |-> q_reg.x == 16'h0000 && q_reg.y == 16'h0000 && m_tdata == '0;
    endproperty
    a_sof_first: assert property (p_sof_first) else $error("frame start off first pixel");

    property p_sof_once;
        tx_take && m_tuser[0] && !(tx_last_x && tx_last_y) |=> !m_tuser[0] ##1 !m_tuser[0];
    endproperty
    a_sof_once: assert property (p_sof_once) else $error("frame start on second beat");

    property p_eol_place;
        m_tvalid |-> m_tlast == tx_last_x;
    endproperty
    a_eol_place: assert property (p_eol_place) else $error("line end misplaced");

    property p_ready_indep;
        $rose(s_tvalid) |-> s_tready == $past(q_reg.ctrl[VSP_CTRL_SINK_EN]);
    endproperty
    a_ready_indep: assert property (p_ready_indep) else $error("ready followed valid");

    property p_stall_in_reset;
        !dev_rst_n || !dev_clk_en |=> $stable(q_reg.x) && $stable(q_reg.y) &&
            $stable(q_reg.rx_lines);
    endproperty
    a_stall_in_reset: assert property (p_stall_in_reset) else $error("beat moved while gated");

    property p_rx_frame_count;
        rx_take && s_tuser[0] |=> q_reg.rx_frames == 16'($past(q_reg.rx_frames) + 16'h0001);
    endproperty
    a_rx_frame_count: assert property (p_rx_frame_count) else $error("frame start not counted");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");

    property p_no_start_gated;
        !dev_clk_en && !m_tvalid |=> !m_tvalid;
    endproperty
    a_no_start_gated: assert property (p_no_start_gated) else $error("beat offered while gated");
endmodule

//--- hdl/vsp_pkg.sv
// shared constants of the video stream port controller
package vsp_pkg;
    // register byte offsets on the wishbone side
    localparam logic [7:0] VSP_CTRL_OFS = 8'h00;
    localparam logic [7:0] VSP_FRAME_OFS = 8'h04;
    localparam logic [7:0] VSP_COUNT_OFS = 8'h08;
    localparam logic [7:0] VSP_RXDATA_OFS = 8'h0C;
    localparam logic [7:0] VSP_STATUS_OFS = 8'h10;
    localparam logic [7:0] VSP_LINES_OFS = 8'h14;
    // control field positions
    localparam int VSP_CTRL_SRC_EN = 0;
    localparam int VSP_CTRL_SINK_EN = 1;
    localparam int VSP_CTRL_CLK_EN = 2;
    localparam int VSP_CTRL_DEV_RST = 3;
    localparam int VSP_CTRL_W = 4;
    // frame size field positions
    localparam int VSP_FRAME_WIDTH_LSB = 0;
    localparam int VSP_FRAME_HEIGHT_LSB = 16;
    localparam int VSP_DIM_W = 16;
    // values after reset: clock enable on, device held in reset
    localparam logic [3:0] VSP_CTRL_RST = 4'h4 | 4'h8;
    localparam logic [15:0] VSP_WIDTH_RST = 16'h0000;
    localparam logic [15:0] VSP_HEIGHT_RST = 16'h0000;
    localparam logic [15:0] VSP_COUNT_RST = 16'h0000;
    typedef enum logic [0:0] {VSP_SRC_IDLE, VSP_SRC_SEND} vsp_src_e;
endpackage

//--- testbench/vsp_core_model.sv
// behavioural video core: one-entry loopback from its stream input to its stream output
`timescale 1ns/10ps
module vsp_core_model #(
    parameter int FRAME_BEATS = 4
) (
    input wire logic clk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic stall,
    // three packed 8-bit components, already a whole number of bytes
    input wire logic [23:0] i_data,
    input wire logic i_valid,
    input wire logic i_user,
    input wire logic i_last,
    output logic i_ready = 1'b0,
    output logic [23:0] o_data = 24'h000000,
    output logic o_valid = 1'b0,
    output logic o_user = 1'b0,
    output logic o_last = 1'b0,
    input wire logic o_ready,
    output logic early_frame_start_flag = 1'b0,
    output logic late_frame_start_flag = 1'b0
);
    // no id or destination outputs exist, so both read as zero downstream
    logic full;
    logic synced = 1'b0;
    logic keep_beat;
    int pos = 0;
    // beats of a frame that never started are taken but not forwarded
    assign keep_beat = i_user || (synced && pos != FRAME_BEATS);
    // slot still taken after this edge; ready is registered from it, never from valid directly
    assign full = (i_ready && i_valid && keep_beat) || (o_valid && !o_ready);
    always @(posedge clk) begin
        if (!aresetn) begin
            o_valid <= 1'b0;
            i_ready <= 1'b0;
            synced <= 1'b0;
            pos <= 0;
            early_frame_start_flag <= 1'b0;
            late_frame_start_flag <= 1'b0;
        end else if (aclken) begin
            if (o_valid && o_ready) begin
                o_valid <= 1'b0;
                o_data <= ~o_data;
            end
            if (i_ready && i_valid) begin
                // an early start restarts at once; the old frame's last beat never arrived and is not waited for
                if (i_user) begin
                    if (synced && pos != FRAME_BEATS) begin
                        early_frame_start_flag <= 1'b1;
                    end
                    pos <= 1;
                    synced <= 1'b1;
                end else if (keep_beat) begin
                    pos <= pos + 1;
                end else if (synced) begin
                    late_frame_start_flag <= 1'b1;
                    synced <= 1'b0;
                end
                if (keep_beat) begin
                    // data passes unchanged, so zero-filled chroma lines arrive as sent
                    o_data <= i_data;
                    o_user <= i_user;
                    o_last <= i_last;
                    o_valid <= 1'b1;
                end
            end
            i_ready <= !stall && !full;
        end
    end
endmodule

//--- testbench/vsp_ctrl_tb.sv
// self-checking bench for the stream port controller with a loopback core model
`timescale 1ns/10ps
module vsp_ctrl_tb;
    import vsp_pkg::*;
    localparam int W = 2;
    localparam int H = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, stall = 1'b0, pend = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, dev_rst_n, dev_clk_en, m_tvalid, m_tready, m_tlast;
    logic s_tvalid, s_tready, s_tlast;
    logic [0:0] m_tuser, s_tuser;
    logic [23:0] m_tdata, s_tdata, last_rx;
    logic [2:0] m_tkeep, m_tstrb;
    logic [26:0] prev;
    logic early_frame_start_flag, late_frame_start_flag;
    int n_mismatch = 0, compares = 0, cycles = 0, idx = 0, beats = 0, s_sof = 0, s_eol = 0, n;

    vsp_ctrl #(.DW(24), .UW(1)) u_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_rst_n(dev_rst_n),
        .dev_clk_en(dev_clk_en), .m_tdata(m_tdata), .m_tvalid(m_tvalid), .m_tready(m_tready),
        .m_tuser(m_tuser), .m_tlast(m_tlast), .m_tkeep(m_tkeep), .m_tstrb(m_tstrb),
        .s_tdata(s_tdata), .s_tvalid(s_tvalid), .s_tready(s_tready), .s_tuser(s_tuser),
        .s_tlast(s_tlast));
    // core enable comes from the controller's enable, the same one the controller obeys
    vsp_core_model #(.FRAME_BEATS(W * H)) u_core (.clk(clk), .aresetn(dev_rst_n),
        .aclken(dev_clk_en), .stall(stall),
        .i_data(m_tdata), .i_valid(m_tvalid), .i_user(m_tuser[0]), .i_last(m_tlast),
        .i_ready(m_tready), .o_data(s_tdata), .o_valid(s_tvalid), .o_user(s_tuser[0]),
        .o_last(s_tlast), .o_ready(s_tready), .early_frame_start_flag(early_frame_start_flag),
        .late_frame_start_flag(late_frame_start_flag));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000, 4'hF);
        chk(rd, exp);
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // wire monitor: beat order, markers and holding while stalled
    always @(posedge clk) begin
        if (!dev_rst_n) begin
            idx = 0;
        end else begin
            if (pend)
                chk({m_tvalid, m_tuser, m_tlast, m_tdata}, prev);
            if (m_tvalid && m_tready && dev_clk_en) begin
                chk({m_tuser, m_tlast, m_tdata}, {idx == 0, idx % W == W - 1, idx[23:0]});
                chk({m_tkeep, m_tstrb}, 32'h0000003F);
                idx = (idx + 1) % (W * H);
                beats++;
            end
            if (s_tvalid && s_tready && dev_clk_en) begin
                s_sof += s_tuser;
                s_eol += s_tlast;
                last_rx = s_tdata;
            end
        end
        pend = m_tvalid && !(m_tready && dev_clk_en) && dev_rst_n;
        prev = {m_tvalid, m_tuser, m_tlast, m_tdata};
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk(VSP_CTRL_OFS, 32'h0000000C);
        rdchk(VSP_FRAME_OFS, 32'h00000000);
        rdchk(VSP_COUNT_OFS, 32'h00000000);
        rdchk(VSP_STATUS_OFS, 32'h00000000);
        rdchk(8'h1C, 32'h00000000);
        chk({dev_rst_n, dev_clk_en, m_tvalid}, 32'h00000002);
        $display("test reset values done");
        wb(1'b1, VSP_FRAME_OFS, {16'(H), 16'(W)}, 4'hF);
        rdchk(VSP_FRAME_OFS, {16'(H), 16'(W)});
        wb(1'b1, VSP_CTRL_OFS, 32'h00000007, 4'h1);
        wb(1'b1, VSP_CTRL_OFS, 32'h00000000, 4'h0);
        rdchk(VSP_CTRL_OFS, 32'h00000007);
        repeat (60) @(posedge clk) stall <= ~stall;
        $display("test stream with backpressure done");
        wb(1'b1, VSP_CTRL_OFS, 32'h00000003, 4'h1);
        // the enable register lags the write by one edge, so a last beat may still pass
        repeat (2) @(posedge clk);
        n = beats;
        repeat (12) @(posedge clk) stall <= ~stall;
        chk(beats, n);
        wb(1'b1, VSP_CTRL_OFS, 32'h00000007, 4'h1);
        repeat (30) @(posedge clk);
        wb(1'b1, VSP_CTRL_OFS, 32'h00000006, 4'h1);
        repeat (40) @(posedge clk);
        wb(1'b0, VSP_COUNT_OFS, 32'h00000000, 4'hF);
        chk(rd[31:16], s_sof);
        chk(rd[15:0], beats / (W * H));
        chk({early_frame_start_flag, late_frame_start_flag}, 32'h00000000);
        rdchk(VSP_LINES_OFS, s_eol);
        rdchk(VSP_RXDATA_OFS, last_rx);
        rdchk(VSP_STATUS_OFS, {30'h0, s_sof > 0, 1'b0});
        $display("test clock enable and counters done");
        wb(1'b1, VSP_CTRL_OFS, 32'h00000007, 4'h1);
        repeat (5) @(posedge clk);
        wb(1'b1, VSP_CTRL_OFS, 32'h0000000B, 4'h1);
        repeat (3) @(posedge clk);
        chk({dev_rst_n, m_tvalid, s_tvalid}, 32'h00000000);
        n = beats;
        wb(1'b1, VSP_CTRL_OFS, 32'h00000007, 4'h1);
        repeat (30) @(posedge clk);
        chk(beats > n + W * H, 32'h00000001);
        chk({early_frame_start_flag, late_frame_start_flag}, 32'h00000000);
        $display("test device reset mid-frame done");
        finish_test();
    end
endmodule
